// >>> pkg/wkt_pkg.sv
// constants, types and register map of the wakeup countdown timer
package wkt_pkg;

  // ==========================================================================
  // clock and time
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SRC_PERIOD_NS  = 244_140;    // 4096 Hz source
  localparam int unsigned REL_SHORT_NS   = 122_000;    // 122 us
  localparam int unsigned REL_LONG_NS    = 7_813_000;  // 7.813 ms
  localparam int unsigned BASE_DIV_CYC   = SRC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned REL_SHORT_CYC  =
    (REL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REL_LONG_CYC   =
    (REL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // divider chain ratios below the 4096 Hz stage
  localparam logic [5:0]  DIV_64_M1      = 6'h3f;   // 4096 Hz -> 64 Hz
  localparam logic [5:0]  DIV_1HZ_M1     = 6'h3f;   // 64 Hz -> 1 Hz
  localparam logic [5:0]  DIV_MIN_M1     = 6'h3b;   // 1 Hz -> 1/60 Hz
  localparam logic [5:0]  DIV_HOUR_M1    = 6'h3b;   // 1/60 Hz -> 1/3600 Hz
  localparam int unsigned SRC_N          = 5;
  localparam int unsigned REL_W          = 18;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam int unsigned ADDR_W         = 12;
  localparam logic [9:0]  IDX_PRESET_LO  = 10'h01b;
  localparam logic [9:0]  IDX_PRESET_HI  = 10'h01c;
  localparam logic [9:0]  IDX_EXT        = 10'h01d;
  localparam logic [9:0]  IDX_FLAG       = 10'h01e;
  localparam logic [9:0]  IDX_CTRL       = 10'h01f;
  localparam logic [9:0]  IDX_PINCTL     = 10'h032;
  localparam logic [9:0]  IDX_INT_STAT   = 10'h040;
  localparam logic [9:0]  IDX_INT_CLR    = 10'h041;
  localparam logic [9:0]  IDX_INT_EN     = 10'h042;

  // field positions
  localparam int unsigned EXT_RUN_BIT    = 4;
  localparam int unsigned EXT_SEL_LSB    = 0;
  localparam int unsigned FLAG_EVT_BIT   = 4;
  localparam int unsigned CTRL_FRZ_BIT   = 6;
  localparam int unsigned CTRL_IRQEN_BIT = 4;
  localparam int unsigned CTRL_HOLD_BIT  = 2;
  localparam int unsigned PIN_SEL_BIT    = 2;
  localparam int unsigned PIN_ONE_LVL    = 4;
  localparam int unsigned PIN_TWO_LVL    = 5;
  localparam int unsigned INT_EVT_BIT    = 0;
  localparam int unsigned INT_REL_BIT    = 1;
  localparam int unsigned INT_W          = 2;

  // reset values
  localparam logic [15:0] RST_PRESET     = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;

  typedef enum logic [2:0] {
    SRC_4096 = 3'b000,
    SRC_64   = 3'b001,
    SRC_1HZ  = 3'b010,
    SRC_MIN  = 3'b011,
    SRC_HOUR = 3'b100
  } wkt_src_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10
  } wkt_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } wkt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wkt_apb_rsp_t;

  typedef struct packed {
    logic line_one_o;
    logic line_one_oe_n;
    logic line_two_o;
    logic line_two_oe_n;
  } wkt_irq_pins_t;

endpackage : wkt_pkg

// >>> hw/wkt_divider.sv
// single divider chain producing all countdown source ticks
`timescale 1ns/10ps
`default_nettype none
module wkt_divider
  import wkt_pkg::*;
#(
  parameter int unsigned BASE_DIV = wkt_pkg::BASE_DIV_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  output logic [wkt_pkg::SRC_N-1:0]       tick_o
);

  // ==========================================================================
  // chain: ticks are one-cycle pulses, all stages aligned
  localparam logic [15:0] BASE_M1 = 16'(BASE_DIV - 1);

  function automatic logic [5:0] step(input logic [5:0] cnt,
                                      input logic       en,
                                      input logic       wrap);
    if (!en)
      return cnt;
    return wrap ? 6'h00 : cnt + 6'h01;
  endfunction : step

  logic [15:0] base_q;
  logic [5:0]  c64_q;
  logic [5:0]  c1_q;
  logic [5:0]  cm_q;
  logic [5:0]  ch_q;

  wire t4096 = (base_q == BASE_M1);
  wire t64   = t4096 & (c64_q == DIV_64_M1);
  wire t1    = t64 & (c1_q == DIV_1HZ_M1);
  wire tmin  = t1 & (cm_q == DIV_MIN_M1);
  wire thour = tmin & (ch_q == DIV_HOUR_M1);

  // free running, so the first period after a start is short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= '0;
      c64_q  <= '0;
      c1_q   <= '0;
      cm_q   <= '0;
      ch_q   <= '0;
      tick_o <= '0;
    end else begin
      base_q <= t4096 ? 16'h0000 : base_q + 16'h0001;
      c64_q  <= step(c64_q, t4096, t64);
      c1_q   <= step(c1_q, t64, t1);
      cm_q   <= step(cm_q, t1, tmin);
      ch_q   <= step(ch_q, tmin, thour);
      tick_o <= {thour, tmin, t1, t64, t4096};
    end
  end

endmodule : wkt_divider
`default_nettype wire

// >>> hw/wkt_timer.sv
// wakeup countdown timer with apb registers and open-drain irq lines
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module wkt_timer
#(
  parameter int unsigned BASE_DIV = wkt_pkg::BASE_DIV_CYC,
  parameter int unsigned REL_LONG = wkt_pkg::REL_LONG_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire wkt_pkg::wkt_apb_req_t  apb_req,
  output wkt_pkg::wkt_apb_rsp_t       apb_rsp,
  input  wire logic                   scl,
  input  wire logic                   irq_line_one_i,
  input  wire logic                   irq_line_two_i,
  output wkt_pkg::wkt_irq_pins_t      irq_pins,
  output logic                        int_o
);
  import wkt_pkg::*;

  // ==========================================================================
  // apb decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0]        idx);
    return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
  endfunction : hit

  function automatic logic slow_src(input logic [2:0] sel);
    return sel != SRC_4096;
  endfunction : slow_src

  wire setup_ph  = apb_req.psel & ~apb_req.penable;
  wire access_ph = apb_req.psel & apb_req.penable;
  wire wr        = access_ph & apb_req.pwrite;
  wire hit_plo   = hit(apb_req.paddr, IDX_PRESET_LO);
  wire hit_phi   = hit(apb_req.paddr, IDX_PRESET_HI);
  wire hit_ext   = hit(apb_req.paddr, IDX_EXT);
  wire hit_flag  = hit(apb_req.paddr, IDX_FLAG);
  wire hit_ctrl  = hit(apb_req.paddr, IDX_CTRL);
  wire hit_pin   = hit(apb_req.paddr, IDX_PINCTL);
  wire hit_ist   = hit(apb_req.paddr, IDX_INT_STAT);
  wire hit_iclr  = hit(apb_req.paddr, IDX_INT_CLR);
  wire hit_ien   = hit(apb_req.paddr, IDX_INT_EN);
  wire mapped    = hit_plo | hit_phi | hit_ext | hit_flag | hit_ctrl |
                   hit_pin | hit_ist | hit_iclr | hit_ien;
  wire [31:0] wd = apb_req.pwdata;

  wire wr_plo  = wr & hit_plo;
  wire wr_phi  = wr & hit_phi;
  wire wr_ext  = wr & hit_ext;
  wire wr_flag = wr & hit_flag;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_pin  = wr & hit_pin;
  wire wr_iclr = wr & hit_iclr;
  wire wr_ien  = wr & hit_ien;

  // ==========================================================================
  // registers
  logic [15:0]      preset_q;
  logic [15:0]      count_q;
  logic             run_en_q;
  logic [2:0]       src_sel_q;
  logic             evt_flag_q;
  logic             freeze_q;
  logic             irq_en_q;
  logic             hold_q;
  logic             pin_sel_q;
  logic             line_low_q;
  logic [REL_W-1:0] rel_cnt_q;
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_en_q;
  logic [31:0]      prdata_q;
  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic [2:0]       sync3_q;
  logic [2:0]       filt_q;
  wkt_state_t       state_q;
  wkt_state_t       state_d;

  // ==========================================================================
  // pin sampling: scl, line one level, line two level
  wire [2:0] agree  = ~(sync2_q ^ sync3_q);
  wire [2:0] filt_d = (agree & sync3_q) | (~agree & filt_q);
  wire scl_rise     = filt_d[2] & ~filt_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // pins idle high; a zero here would fake an scl rise after reset
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      filt_q  <= '1;
    end else begin
      sync1_q <= {scl, irq_line_one_i, irq_line_two_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // ==========================================================================
  // source select and countdown
  logic [SRC_N-1:0] tick;

  wkt_divider #(
    .BASE_DIV (BASE_DIV)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_o  (tick)
  );

  // codes above the hourly source select no tick
  wire src_tick  = (src_sel_q < 3'(SRC_N)) & tick[src_sel_q];
  wire slow      = slow_src(src_sel_q);
  wire paused    = hold_q | (freeze_q & slow);
  wire counting  = (state_q == ST_COUNT) & src_tick & ~paused;
  // a zero preset never reaches one, so it raises no event
  wire evt       = counting & (count_q == CNT_ONE);
  wire run_rise  = wr_ext & wd[EXT_RUN_BIT] & ~run_en_q;
  wire run_fall  = wr_ext & ~wd[EXT_RUN_BIT];
  wire irq_off   = wr_ctrl & ~wd[CTRL_IRQEN_BIT];
  wire drive_evt = evt & irq_en_q & ~irq_off;
  wire rel_done  = line_low_q & (rel_cnt_q == '0);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (run_rise) state_d = ST_ARMED;
      ST_ARMED: begin
        if (run_fall)
          state_d = ST_IDLE;
        else if (scl_rise)
          state_d = ST_COUNT;
      end
      ST_COUNT: if (run_fall) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      count_q <= RST_PRESET;
    end else begin
      state_q <= state_d;
      if (run_rise || evt)
        count_q <= preset_q;
      else if (counting && count_q != '0)
        count_q <= count_q - CNT_ONE;
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_q  <= RST_PRESET;
      run_en_q  <= 1'b0;
      src_sel_q <= SRC_4096;
      freeze_q  <= 1'b0;
      irq_en_q  <= 1'b0;
      hold_q    <= 1'b0;
      pin_sel_q <= 1'b0;
      int_en_q  <= '0;
    end else begin
      if (wr_plo) preset_q[7:0]  <= wd[7:0];
      if (wr_phi) preset_q[15:8] <= wd[7:0];
      if (wr_ext) begin
        run_en_q  <= wd[EXT_RUN_BIT];
        src_sel_q <= wd[EXT_SEL_LSB +: 3];
      end
      if (wr_ctrl) begin
        freeze_q <= wd[CTRL_FRZ_BIT];
        irq_en_q <= wd[CTRL_IRQEN_BIT];
        hold_q   <= wd[CTRL_HOLD_BIT];
      end
      if (wr_pin) pin_sel_q <= wd[PIN_SEL_BIT];
      if (wr_ien) int_en_q  <= wd[INT_W-1:0];
    end
  end

  // ==========================================================================
  // event flag, irq line and auto release
  // set wins over a clear that lands in the same cycle
  wire flag_d = evt | (evt_flag_q &
                ~(wr_flag & ~wd[FLAG_EVT_BIT]));
  wire line_d = irq_off ? 1'b0 :
                drive_evt ? 1'b1 :
                rel_done ? 1'b0 : line_low_q;
  wire [REL_W-1:0] rel_load = slow ? REL_W'(REL_LONG - 1)
                                   : REL_W'(REL_SHORT_CYC - 1);
  wire [INT_W-1:0] int_set  = {rel_done & ~irq_off & ~drive_evt, evt};
  wire [INT_W-1:0] int_clr  = wr_iclr ? wd[INT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_flag_q <= 1'b0;
      line_low_q <= 1'b0;
      rel_cnt_q  <= '0;
      int_stat_q <= '0;
    end else begin
      evt_flag_q <= flag_d;
      line_low_q <= line_d;
      if (drive_evt)
        rel_cnt_q <= rel_load;
      else if (line_low_q && rel_cnt_q != '0)
        rel_cnt_q <= rel_cnt_q - REL_W'(1);
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
    end
  end

  // open drain: only ever pull low, enable low while pulling
  assign irq_pins.line_one_o    = 1'b0;
  assign irq_pins.line_two_o    = 1'b0;
  assign irq_pins.line_one_oe_n = ~(line_low_q & pin_sel_q);
  assign irq_pins.line_two_oe_n = ~(line_low_q & ~pin_sel_q);
  assign int_o = |(int_stat_q & int_en_q);

  // ==========================================================================
  // read path: data captured in setup, answered with no wait state
  logic [7:0] rd_d;
  wire [15:0] cnt_view = run_en_q ? count_q : preset_q;

  always_comb begin
    rd_d = 8'h00;
    if (hit_plo)  rd_d = cnt_view[7:0];
    if (hit_phi)  rd_d = cnt_view[15:8];
    if (hit_ext)  rd_d = {3'b000, run_en_q, 1'b0, src_sel_q};
    if (hit_flag) rd_d = {3'b000, evt_flag_q, 4'h0};
    if (hit_ctrl) rd_d = {1'b0, freeze_q, 1'b0, irq_en_q, 1'b0, hold_q,
                          2'b00};
    if (hit_pin)  rd_d = {2'b00, filt_q[0], filt_q[1], 1'b0, pin_sel_q,
                          2'b00};
    if (hit_ist)  rd_d = {6'h00, int_stat_q};
    if (hit_ien)  rd_d = {6'h00, int_en_q};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_q <= '0;
    else if (setup_ph)
      prdata_q <= {24'h000000, rd_d};
  end

  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access_ph & ~mapped;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    run_rise ##1 (state_q == ST_ARMED);
  endsequence
  sequence s_ack_edge;
    (state_q == ST_ARMED) && !run_fall && scl_rise;
  endsequence

  a_start_from_preset: assert property (
    run_rise |=> count_q == $past(preset_q))
    else $error("start did not load preset");
  a_start_at_ack: assert property (
    s_start ##[0:20] s_ack_edge |=> state_q == ST_COUNT)
    else $error("count did not begin at scl rise");
  a_stopped_readback: assert property (
    setup_ph && hit_plo && !run_en_q |=> prdata_q[7:0] == preset_q[7:0])
    else $error("stopped read is not preset");
  a_flag_sticky: assert property (
    evt |=> evt_flag_q ##1 (evt_flag_q || $past(wr_flag)))
    else $error("event flag not held");
  a_flag_write_one: assert property (
    wr_flag && wd[FLAG_EVT_BIT] && evt_flag_q |=> evt_flag_q)
    else $error("writing one changed flag");
  a_flag_clear: assert property (
    wr_flag && !wd[FLAG_EVT_BIT] && !evt && line_low_q && !rel_done
      && !irq_off |=> !evt_flag_q && line_low_q)
    else $error("flag clear wrong or line released");
  a_run_off_line: assert property (
    run_fall && line_low_q && !rel_done && !irq_off |=> line_low_q)
    else $error("run disable released line");
  a_irq_off_release: assert property (
    irq_off |=> !line_low_q && irq_pins.line_one_oe_n
      && irq_pins.line_two_oe_n)
    else $error("irq disable kept line low");
  a_event_drives: assert property (
    drive_evt |=> (pin_sel_q ? !irq_pins.line_one_oe_n
                             : !irq_pins.line_two_oe_n))
    else $error("event did not pull selected line");
  a_reload_after: assert property (
    evt && !wr_plo && !wr_phi |=> count_q == preset_q)
    else $error("no reload after event");
  a_hold_pause: assert property (
    state_q == ST_COUNT && paused && !run_fall |=> $stable(count_q))
    else $error("count moved while paused");
  a_short_release: assert property (
    drive_evt && !slow |=> rel_cnt_q == REL_W'(REL_SHORT_CYC - 1))
    else $error("wrong short release time");

endmodule : wkt_timer
`default_nettype wire

// >>> dv/wkt_scl_host.sv
// serial host model: one write frame of scl pulses per request
`timescale 1ns/10ps
`default_nettype none
module wkt_scl_host (
  input  wire logic go,
  output logic      scl
);
  // ==========================================================================
  // frame generator
  // scl idles high on its pull-up and stands still between frames
  initial begin
    scl = 1'b1;
  end
  // ten rises per frame; the device arms on the write and must wait for one
  always @(posedge go) begin
    #167 scl = 1'b0;
    repeat (9) begin
      #160 scl = 1'b1;
      #160 scl = 1'b0;
    end
    #160 scl = 1'b1;
  end
endmodule : wkt_scl_host
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the wakeup countdown timer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wkt_pkg::*;
  // ==========================================================================
  // setup
  localparam int unsigned BD    = 4;
  localparam int unsigned RL    = 40;
  localparam int unsigned T64   = (DIV_64_M1 + 1) * BD;
  localparam logic [11:0] A_LO  = {IDX_PRESET_LO, 2'b00};
  localparam logic [11:0] A_HI  = {IDX_PRESET_HI, 2'b00};
  localparam logic [11:0] A_EXT = {IDX_EXT, 2'b00};
  localparam logic [11:0] A_FLG = {IDX_FLAG, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_PIN = {IDX_PINCTL, 2'b00};
  localparam logic [11:0] A_IST = {IDX_INT_STAT, 2'b00};
  localparam logic [11:0] A_ICL = {IDX_INT_CLR, 2'b00};
  localparam logic [11:0] A_IEN = {IDX_INT_EN, 2'b00};
  logic          pclk, presetn, scl, go, lo, lo_q, irq_one, irq_two, int_o;
  logic          e;
  logic [31:0]   r;
  wkt_apb_req_t  req;
  wkt_apb_rsp_t  rsp;
  wkt_irq_pins_t pins;
  int            n_fail, tests_run, cyc, n_ev, n_rl, last_fall, prev_fall;
  int            last_rise, t0, n0;

  wkt_timer #(.BASE_DIV(BD), .REL_LONG(RL)) dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .scl(scl), .irq_line_one_i(irq_one), .irq_line_two_i(irq_two),
    .irq_pins(pins), .int_o(int_o));
  wkt_scl_host host (.go(go), .scl(scl));

  // open-drain lines with pull-ups
  assign irq_one = pins.line_one_oe_n ? 1'b1 : pins.line_one_o;
  assign irq_two = pins.line_two_oe_n ? 1'b1 : pins.line_two_o;
  assign lo      = ~(pins.line_one_oe_n & pins.line_two_oe_n);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // edge log of the irq lines, in pclk cycles
  always @(posedge pclk) begin
    cyc  <= cyc + 1;
    lo_q <= lo;
    if (lo && !lo_q) begin
      prev_fall <= last_fall;
      last_fall <= cyc;
      n_ev      <= n_ev + 1;
    end
    if (!lo && lo_q) begin
      last_rise <= cyc;
      n_rl      <= n_rl + 1;
    end
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    tests_run = tests_run + 1;
    if (s !== x) begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no local cap: only the bench timeout may end this wait
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic arm(input logic [15:0] p, input logic [2:0] s,
                     input logic [7:0] c);
    wr(A_EXT, {29'h0, s});
    wr(A_LO, {24'h0, p[7:0]});
    wr(A_HI, {24'h0, p[15:8]});
    wr(A_CTL, {24'h0, c});
    wr(A_EXT, {27'h0, 2'b10, s});
  endtask : arm

  task automatic kick();
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask : kick

  // wait for the next fall (rise=0) or release (rise=1) of the irq lines
  task automatic wt(input bit rise, input int lim);
    int k;
    int m;
    k = 0;
    m = rise ? n_rl : n_ev;
    while ((rise ? n_rl : n_ev) == m && k < lim) begin
      @(posedge pclk);
      k++;
    end
    chk("edge wait", 32'(k < lim), 32'h1);
  endtask : wt

  task automatic poll(input int lim);
    int k;
    k = 0;
    do begin
      apb(1'b0, A_FLG, 32'h0);
      k++;
    end while (r[FLAG_EVT_BIT] !== 1'b1 && k < lim);
  endtask : poll

  task automatic halt();
    wr(A_EXT, 32'h0);
    wr(A_CTL, 32'h0);
    wr(A_FLG, 32'h0);
    wr(A_ICL, 32'h3);
  endtask : halt

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [11:0] ad [8];
    logic [31:0] ex [8];
    ad = '{A_EXT, A_FLG, A_CTL, A_PIN, A_IEN, A_IST, A_LO, A_HI};
    ex = '{32'h0, 32'h0, 32'h0, 32'h30, 32'h0, 32'h0, 32'h0, 32'h0};
    foreach (ad[i]) begin
      apb(1'b0, ad[i], 32'h0);
      chk("reset value", r, ex[i]);
    end
    apb(1'b0, 12'h3fc, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
    for (int s = 0; s < 5; s++) begin
      wr(A_EXT, 32'(s));
      apb(1'b0, A_EXT, 32'h0);
      chk("source select", r, 32'(s));
    end
    wr(A_LO, 32'h5a);
    wr(A_HI, 32'hc3);
    apb(1'b0, A_LO, 32'h0);
    chk("stopped preset lo", r, 32'h5a);
    apb(1'b0, A_HI, 32'h0);
    chk("stopped preset hi", r, 32'hc3);
  endtask : t_regs

  task automatic t_period();
    wr(A_IEN, 32'h1);
    arm(16'h0002, SRC_64, 8'h10);
    kick();
    wt(1'b0, 4 * T64);
    chk("line one idle", 32'(pins.line_one_oe_n), 32'h1);
    chk("line two low", 32'(pins.line_two_oe_n), 32'h0);
    apb(1'b0, A_FLG, 32'h0);
    chk("event flag", r, 32'h10);
    apb(1'b0, A_PIN, 32'h0);
    chk("wire levels", r & 32'h30, 32'h10);
    apb(1'b0, A_IST, 32'h0);
    chk("int status", r, 32'h1);
    chk("int out", 32'(int_o), 32'h1);
    wr(A_IEN, 32'h0);
    @(posedge pclk);
    chk("int masked", 32'(int_o), 32'h0);
    wr(A_ICL, 32'h1);
    apb(1'b0, A_IST, 32'h0);
    chk("int cleared", r, 32'h0);
    wr(A_IEN, 32'h3);
    wt(1'b1, 200);
    apb(1'b0, A_IST, 32'h0);
    chk("release status", r, 32'h2);
    wt(1'b0, 4 * T64);
    chk("long release", 32'(last_rise - prev_fall), 32'(RL));
    chk("period", 32'(last_fall - prev_fall), 32'(2 * T64));
    halt();
    wr(A_IEN, 32'h0);
  endtask : t_period

  task automatic t_release();
    wr(A_PIN, 32'h4);
    arm(16'd1000, SRC_4096, 8'h10);
    kick();
    wt(1'b0, 5000);
    chk("pin one low", 32'(pins.line_one_oe_n), 32'h0);
    chk("pin two idle", 32'(pins.line_two_oe_n), 32'h1);
    wr(A_FLG, 32'h10);
    apb(1'b0, A_FLG, 32'h0);
    chk("flag write one", r, 32'h10);
    apb(1'b0, A_PIN, 32'h0);
    chk("wire levels one", r & 32'h30, 32'h20);
    wr(A_FLG, 32'h0);
    apb(1'b0, A_FLG, 32'h0);
    chk("flag cleared", r, 32'h0);
    chk("line after clear", 32'(lo), 32'h1);
    wr(A_FLG, 32'h10);
    apb(1'b0, A_FLG, 32'h0);
    chk("flag stays clear", r, 32'h0);
    wt(1'b1, 4000);
    chk("short release", 32'(last_rise - last_fall),
        32'(REL_SHORT_CYC));
    wt(1'b0, 5000);
    chk("long period", 32'(last_fall - prev_fall), 32'(1000 * BD));
    wr(A_EXT, 32'h0);
    @(posedge pclk);
    chk("line after stop", 32'(lo), 32'h1);
    wr(A_CTL, 32'h0);
    @(posedge pclk);
    @(posedge pclk);
    chk("line released", 32'(lo), 32'h0);
    halt();
    wr(A_PIN, 32'h0);
  endtask : t_release

  task automatic t_restart();
    arm(16'h0003, SRC_64, 8'h10);
    n0 = n_ev;
    repeat (1200) @(posedge pclk);
    chk("no count before scl", 32'(n_ev), 32'(n0));
    kick();
    repeat (3 * T64 / 2) @(posedge pclk);
    wr(A_EXT, {29'h0, SRC_64});
    apb(1'b0, A_LO, 32'h0);
    chk("preset after stop", r, 32'h3);
    wr(A_EXT, {27'h0, 2'b10, SRC_64});
    t0 = cyc;
    kick();
    wt(1'b0, 1000);
    chk("full restart", 32'(last_fall - t0 > 2 * T64 &&
        last_fall - t0 <= 3 * T64 + 40), 32'h1);
    halt();
  endtask : t_restart

  task automatic t_hold();
    arm(16'h0002, SRC_64, 8'h04);
    kick();
    n0 = n_ev;
    repeat (1200) @(posedge pclk);
    apb(1'b0, A_FLG, 32'h0);
    chk("held count", r, 32'h0);
    wr(A_CTL, 32'h0);
    poll(300);
    chk("resumed event", r, 32'h10);
    chk("line gated", 32'(n_ev), 32'(n0));
    wr(A_FLG, 32'h0);
    wr(A_CTL, 32'h40);
    repeat (1200) @(posedge pclk);
    apb(1'b0, A_FLG, 32'h0);
    chk("frozen count", r, 32'h0);
    wr(A_CTL, 32'h0);
    poll(300);
    chk("thawed event", r, 32'h10);
    halt();
  endtask : t_hold

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    go      = 1'b0;
    req     = '0;
    n_fail  = 0;
    tests_run = 0;
    {cyc, n_ev, n_rl, last_fall, prev_fall, last_rise, lo_q} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_period();
    t_release();
    t_restart();
    t_hold();
    conclude();
  end
endmodule : tb
`default_nettype wire
